// [namespace_reservation_arbiter.sv]
module namespace_reservation_arbiter
    import resv_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Command request
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [1:0] cmd_op,
    input wire logic [2:0] cmd_action,
    input wire logic [resv_pkg::NS_WIDTH-1:0] cmd_ns,
    input wire logic [resv_pkg::HOST_WIDTH-1:0] cmd_host,
    input wire logic ignore_key_bit,
    input wire logic [7:0] reservation_type_field,
    input wire logic [63:0] current_key_field,
    input wire logic [63:0] preempt_key_field,
    // Completion
    output logic cpl_valid,
    output logic [1:0] cpl_status,
    output logic [resv_pkg::HOST_WIDTH-1:0] cpl_host,
    // Notifications, one bit per host, and the namespace they refer to
    output logic [resv_pkg::HOST_COUNT-1:0] released_notify,
    output logic [resv_pkg::HOST_COUNT-1:0] preempted_notify,
    output logic [resv_pkg::HOST_COUNT-1:0] abort_request,
    output logic [resv_pkg::NS_WIDTH-1:0] event_ns
);
    import resv_pkg::*;

    localparam logic [7:0] ADR_KEY_LO = 8'h00;
    localparam logic [7:0] ADR_KEY_HI = 8'h04;
    localparam logic [7:0] ADR_REG_CTRL = 8'h08;
    localparam logic [7:0] ADR_STATUS = 8'h0C;
    localparam logic [7:0] ADR_STATE = 8'h10;
    localparam int HOLD_W = 1 + HOST_WIDTH + 8;

    // Per-namespace key table and registration bits
    logic [KEY_WIDTH-1:0] key_q [NS_COUNT][HOST_COUNT];
    logic [KEY_WIDTH-1:0] key_d [NS_COUNT][HOST_COUNT];
    logic [HOST_COUNT-1:0] reg_q [NS_COUNT];
    logic [HOST_COUNT-1:0] reg_d [NS_COUNT];
    // Holder record lives in memory: valid, holder, type
    logic [HOLD_W-1:0] hold_rd;
    logic [HOLD_W-1:0] hold_wr;
    logic hold_we;
    logic [NS_WIDTH-1:0] mem_addr;

    state_type state_q, state_d;
    logic [1:0] op_q, op_d;
    logic [2:0] act_q, act_d;
    logic [NS_WIDTH-1:0] ns_q, ns_d;
    logic [HOST_WIDTH-1:0] host_q, host_d;
    logic ign_q, ign_d;
    logic [7:0] typ_q, typ_d;
    logic [63:0] ckey_q, ckey_d;
    logic [63:0] preempt_key_alias_q, preempt_key_alias_d;
    logic [1:0] sts_q, sts_d;
    logic [HOST_COUNT-1:0] rel_q, rel_d;
    logic [HOST_COUNT-1:0] pre_q, pre_d;
    logic [HOST_COUNT-1:0] abt_q, abt_d;
    logic [7:0] stat_cnt_q, stat_cnt_d;
    logic [31:0] key_lo_q, key_lo_d, key_hi_q, key_hi_d;
    logic [31:0] rdat_q, rdat_d;
    logic ack_q, ack_d;

    resv_state_mem #(
        .DEPTH(NS_COUNT),
        .ADDR_WIDTH(NS_WIDTH),
        .DATA_WIDTH(HOLD_W)
    ) hold_mem (
        .clk(clk),
        .rst(rst),
        .addr(mem_addr),
        .wr_en(hold_we),
        .wr_data(hold_wr),
        .rd_data(hold_rd)
    );

    assign mem_addr = (state_q == ST_IDLE) ? cmd_ns : ns_q;
    assign cmd_ready = (state_q == ST_IDLE);

    // Decision logic
    logic h_valid;
    logic [HOST_WIDTH-1:0] h_host;
    logic [7:0] h_type;
    logic is_reg, key_ok, is_holder, all_type, shared_rel;
    logic [HOST_COUNT-1:0] match;
    logic [KEY_WIDTH-1:0] holder_key;

    assign h_valid = hold_rd[HOLD_W-1];
    assign h_host = hold_rd[HOLD_W-2 -: HOST_WIDTH];
    assign h_type = hold_rd[7:0];
    assign is_reg = reg_q[ns_q][host_q];
    assign key_ok = ign_q || (key_q[ns_q][host_q] == ckey_q);
    assign all_type = (h_type == TYPE_WR_EXCL_ALL)
        || (h_type == TYPE_EXCL_ACC_ALL);
    assign is_holder = h_valid && (all_type || (h_host == host_q));
    assign holder_key = key_q[ns_q][h_host];
    assign shared_rel = (h_type != TYPE_WR_EXCL)
        && (h_type != TYPE_EXCL_ACC);

    genvar gh;
    generate
        for (gh = 0; gh < HOST_COUNT; gh++)
        begin : g_match
            assign match[gh] = reg_q[ns_q][gh]
                && (key_q[ns_q][gh] == preempt_key_alias_q);
        end
    endgenerate

    always_comb
    begin
        logic [HOST_COUNT-1:0] regs;
        logic [HOST_COUNT-1:0] unreg;
        logic [HOST_COUNT-1:0] me;
        logic new_res;
        regs = reg_q[ns_q];
        unreg = '0;
        me = '0;
        me[host_q] = 1'b1;
        new_res = 1'b0;
        state_d = state_q;
        op_d = op_q;
        act_d = act_q;
        ns_d = ns_q;
        host_d = host_q;
        ign_d = ign_q;
        typ_d = typ_q;
        ckey_d = ckey_q;
        preempt_key_alias_d = preempt_key_alias_q;
        sts_d = sts_q;
        rel_d = '0;
        pre_d = '0;
        abt_d = '0;
        stat_cnt_d = stat_cnt_q;
        hold_we = 1'b0;
        hold_wr = hold_rd;
        key_d = key_q;
        reg_d = reg_q;
        unique case (state_q)
            ST_IDLE:
            begin
                if (cmd_valid)
                begin
                    op_d = cmd_op;
                    act_d = cmd_action;
                    ns_d = cmd_ns;
                    host_d = cmd_host;
                    ign_d = ignore_key_bit;
                    typ_d = reservation_type_field;
                    ckey_d = current_key_field;
                    preempt_key_alias_d = preempt_key_field;
                    state_d = ST_READ;
                end
            end
            ST_READ:
            begin
                state_d = ST_EXEC;
            end
            ST_EXEC:
            begin
                state_d = ST_DONE;
                sts_d = STS_SUCCESS;
                if (!is_reg || !key_ok)
                begin
                    sts_d = STS_CONFLICT;
                end
                else if (op_q == OP_ACQUIRE && act_q == ACQ_ACQUIRE)
                begin
                    if (!h_valid)
                    begin
                        hold_we = 1'b1;
                        hold_wr = {1'b1, host_q, typ_q};
                    end
                    else if (!is_holder)
                    begin
                        sts_d = STS_CONFLICT;
                    end
                    else if (h_type != typ_q)
                    begin
                        sts_d = STS_CONFLICT;
                    end
                end
                else if (op_q == OP_ACQUIRE && (act_q == ACQ_PREEMPT
                    || act_q == ACQ_PREEMPT_ABORT))
                begin
                    if (!h_valid)
                    begin
                        unreg = match & ~me;
                    end
                    else if (all_type)
                    begin
                        if (preempt_key_alias_q == KEY_ZERO)
                        begin
                            unreg = regs & ~me;
                            new_res = 1'b1;
                        end
                        else
                        begin
                            unreg = match & ~me;
                        end
                    end
                    else if (preempt_key_alias_q == holder_key)
                    begin
                        // Self preempt keeps the caller registered
                        unreg = match & ~me;
                        new_res = 1'b1;
                    end
                    else if (preempt_key_alias_q != KEY_ZERO)
                    begin
                        unreg = match & ~me;
                    end
                    else
                    begin
                        sts_d = STS_INVALID;
                    end
                    if (sts_d == STS_SUCCESS)
                    begin
                        reg_d[ns_q] = regs & ~unreg;
                        pre_d = unreg;
                        if (new_res)
                        begin
                            hold_we = 1'b1;
                            hold_wr = {1'b1, host_q, typ_q};
                            if (typ_q != h_type)
                            begin
                                rel_d = regs & ~unreg & ~me;
                            end
                        end
                        if (act_q == ACQ_PREEMPT_ABORT)
                        begin
                            // Hint only; queued work may already be done
                            abt_d = unreg;
                        end
                    end
                end
                else if (op_q == OP_RELEASE && act_q == REL_RELEASE)
                begin
                    if (!is_holder)
                    begin
                        sts_d = STS_SUCCESS;
                    end
                    else if (typ_q != h_type)
                    begin
                        sts_d = STS_INVALID;
                    end
                    else
                    begin
                        hold_we = 1'b1;
                        hold_wr = '0;
                        if (shared_rel)
                        begin
                            rel_d = regs & ~me;
                        end
                    end
                end
                else
                begin
                    sts_d = STS_INVALID;
                end
                if (sts_d != STS_SUCCESS)
                begin
                    stat_cnt_d = stat_cnt_q + 8'h01;
                end
            end
            ST_DONE:
            begin
                state_d = ST_IDLE;
            end
        endcase
        // Software registration port, idle only to keep updates atomic
        if (state_q == ST_IDLE && !cmd_valid && wb_cyc_i && wb_stb_i
            && wb_we_i && !ack_q && wb_adr_i == ADR_REG_CTRL)
        begin
            key_d[wb_dat_i[9:8]][wb_dat_i[2:0]] = {key_hi_q, key_lo_q};
            reg_d[wb_dat_i[9:8]][wb_dat_i[2:0]] = wb_dat_i[4];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            op_q <= '0;
            act_q <= '0;
            ns_q <= '0;
            host_q <= '0;
            ign_q <= 1'b0;
            typ_q <= '0;
            ckey_q <= '0;
            preempt_key_alias_q <= '0;
            sts_q <= '0;
            rel_q <= '0;
            pre_q <= '0;
            abt_q <= '0;
            stat_cnt_q <= '0;
            for (int n = 0; n < NS_COUNT; n++)
            begin
                reg_q[n] <= '0;
                for (int h = 0; h < HOST_COUNT; h++)
                begin
                    key_q[n][h] <= '0;
                end
            end
        end
        else
        begin
            state_q <= state_d;
            op_q <= op_d;
            act_q <= act_d;
            ns_q <= ns_d;
            host_q <= host_d;
            ign_q <= ign_d;
            typ_q <= typ_d;
            ckey_q <= ckey_d;
            preempt_key_alias_q <= preempt_key_alias_d;
            sts_q <= sts_d;
            rel_q <= rel_d;
            pre_q <= pre_d;
            abt_q <= abt_d;
            stat_cnt_q <= stat_cnt_d;
            key_q <= key_d;
            reg_q <= reg_d;
        end
    end

    assign cpl_valid = (state_q == ST_DONE);
    assign cpl_status = sts_q;
    assign cpl_host = host_q;
    assign released_notify = rel_q;
    assign preempted_notify = pre_q;
    assign abort_request = abt_q;
    assign event_ns = ns_q;

    // Wishbone slave, one wait state; an ADR_REG_CTRL write waits longer while a command is pending or in flight
    always_comb
    begin
        logic req;
        req = wb_cyc_i && wb_stb_i && !ack_q;
        ack_d = req && !(wb_we_i && wb_adr_i == ADR_REG_CTRL
            && (state_q != ST_IDLE || cmd_valid));
        key_lo_d = key_lo_q;
        key_hi_d = key_hi_q;
        rdat_d = rdat_q;
        if (ack_d && wb_we_i)
        begin
            if (wb_adr_i == ADR_KEY_LO)
            begin
                key_lo_d = wb_dat_i;
            end
            if (wb_adr_i == ADR_KEY_HI)
            begin
                key_hi_d = wb_dat_i;
            end
        end
        if (ack_d && !wb_we_i)
        begin
            unique case (wb_adr_i)
                ADR_KEY_LO: rdat_d = key_lo_q;
                ADR_KEY_HI: rdat_d = key_hi_q;
                ADR_STATUS: rdat_d = {22'h00_0000, sts_q, stat_cnt_q};
                ADR_STATE: rdat_d = {16'h0000, reg_q[0],
                    6'h00, state_q};
                default: rdat_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            key_lo_q <= '0;
            key_hi_q <= '0;
            rdat_q <= '0;
            ack_q <= 1'b0;
        end
        else
        begin
            key_lo_q <= key_lo_d;
            key_hi_q <= key_hi_d;
            rdat_q <= rdat_d;
            ack_q <= ack_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
endmodule

// [resv_pkg.sv]
package resv_pkg;
    localparam int HOST_COUNT = 8;
    localparam int HOST_WIDTH = 3;
    localparam int NS_COUNT = 4;
    localparam int NS_WIDTH = 2;
    localparam int KEY_WIDTH = 64;
    localparam logic [63:0] KEY_ZERO = 64'h0000_0000_0000_0000;
    localparam logic [1:0] OP_ACQUIRE = 2'h0;
    localparam logic [1:0] OP_RELEASE = 2'h1;
    localparam logic [2:0] ACQ_ACQUIRE = 3'h0;
    localparam logic [2:0] ACQ_PREEMPT = 3'h1;
    localparam logic [2:0] ACQ_PREEMPT_ABORT = 3'h2;
    localparam logic [2:0] REL_RELEASE = 3'h0;
    localparam logic [7:0] TYPE_WR_EXCL = 8'h01;
    localparam logic [7:0] TYPE_EXCL_ACC = 8'h02;
    localparam logic [7:0] TYPE_WR_EXCL_ALL = 8'h05;
    localparam logic [7:0] TYPE_EXCL_ACC_ALL = 8'h06;
    localparam logic [1:0] STS_SUCCESS = 2'h0;
    localparam logic [1:0] STS_CONFLICT = 2'h1;
    localparam logic [1:0] STS_INVALID = 2'h2;
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_EXEC, ST_DONE} state_type;
endpackage

// [resv_state_mem.sv]
module resv_state_mem
    import resv_pkg::*;
#(
    parameter int DEPTH = NS_COUNT,
    parameter int ADDR_WIDTH = NS_WIDTH,
    parameter int DATA_WIDTH = 8
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Port
    input wire logic [ADDR_WIDTH-1:0] addr,
    input wire logic wr_en,
    input wire logic [DATA_WIDTH-1:0] wr_data,
    output logic [DATA_WIDTH-1:0] rd_data
);
    logic [DATA_WIDTH-1:0] mem_q [DEPTH];
    logic [DATA_WIDTH-1:0] rd_q;

    // Registered read keeps the decision logic off the array
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_q[i] <= '0;
            end
            rd_q <= '0;
        end
        else
        begin
            if (wr_en)
            begin
                mem_q[addr] <= wr_data;
            end
            rd_q <= mem_q[addr];
        end
    end

    assign rd_data = rd_q;
endmodule

// [namespace_reservation_arbiter_asserts.sv]
module namespace_reservation_arbiter_checker
    import resv_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Command
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [1:0] cmd_op,
    input wire logic [2:0] cmd_action,
    input wire logic [resv_pkg::HOST_WIDTH-1:0] cmd_host,
    // Completion and events
    input wire logic cpl_valid,
    input wire logic [1:0] cpl_status,
    input wire logic [resv_pkg::HOST_WIDTH-1:0] cpl_host,
    input wire logic [resv_pkg::HOST_COUNT-1:0] released_notify,
    input wire logic [resv_pkg::HOST_COUNT-1:0] preempted_notify,
    input wire logic [resv_pkg::HOST_COUNT-1:0] abort_request
);
    timeunit 1ns;
    timeprecision 1ns;

    logic take;
    logic quiet;
    assign take = cmd_valid && cmd_ready;
    assign quiet = released_notify == '0 && preempted_notify == '0;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_latency;
        take |-> ##3 cpl_valid && cpl_host == $past(cmd_host, 3);
    endproperty
    a_latency: assert property (p_latency)
        else $error("completion late or wrong host");

    property p_busy;
        take |=> !cmd_ready [*3] ##1 cmd_ready;
    endproperty
    a_busy: assert property (p_busy)
        else $error("ready not held off for one command");

    property p_pulse;
        (|released_notify) || (|preempted_notify) || (|abort_request)
            |-> cpl_valid;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("event pulse outside completion");

    property p_issuer;
        cpl_valid |-> !released_notify[cpl_host] && !preempted_notify[cpl_host];
    endproperty
    a_issuer: assert property (p_issuer)
        else $error("issuer notified");

    property p_fail_quiet;
        cpl_valid && cpl_status != STS_SUCCESS |-> quiet;
    endproperty
    a_fail_quiet: assert property (p_fail_quiet)
        else $error("failed command raised events");

    property p_abort_sub;
        (|abort_request) |-> (abort_request & ~preempted_notify) == '0;
    endproperty
    a_abort_sub: assert property (p_abort_sub)
        else $error("abort to host not preempted");

    property p_release_quiet;
        take && cmd_op == OP_RELEASE
            |-> ##3 preempted_notify == '0 && abort_request == '0;
    endproperty
    a_release_quiet: assert property (p_release_quiet)
        else $error("release preempted a host");

    property p_acquire_quiet;
        take && cmd_op == OP_ACQUIRE && cmd_action == ACQ_ACQUIRE
            |-> ##3 quiet && abort_request == '0;
    endproperty
    a_acquire_quiet: assert property (p_acquire_quiet)
        else $error("plain acquire raised events");

    c_abort: cover property (|abort_request);
    c_released: cover property (|released_notify);
    c_conflict: cover property (cpl_valid && cpl_status == STS_CONFLICT);
endmodule

bind namespace_reservation_arbiter
    namespace_reservation_arbiter_checker chk (
        .clk(clk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op),
        .cmd_action(cmd_action), .cmd_host(cmd_host),
        .cpl_valid(cpl_valid), .cpl_status(cpl_status),
        .cpl_host(cpl_host), .released_notify(released_notify),
        .preempted_notify(preempted_notify),
        .abort_request(abort_request)
    );

// [resv_host_model.sv]
module resv_host_model
    import resv_pkg::*;
(
    // Clock
    input wire logic clk,
    // Command
    output logic cmd_valid,
    input wire logic cmd_ready,
    output logic [1:0] cmd_op,
    output logic [2:0] cmd_action,
    output logic [resv_pkg::NS_WIDTH-1:0] cmd_ns,
    output logic [resv_pkg::HOST_WIDTH-1:0] cmd_host,
    output logic ignore_key_bit,
    output logic [7:0] reservation_type_field,
    output logic [63:0] current_key_field,
    output logic [63:0] preempt_key_field,
    // Completion
    input wire logic cpl_valid,
    input wire logic [1:0] cpl_status,
    input wire logic [resv_pkg::HOST_COUNT-1:0] released_notify,
    input wire logic [resv_pkg::HOST_COUNT-1:0] preempted_notify,
    input wire logic [resv_pkg::HOST_COUNT-1:0] abort_request
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        cmd_valid = 1'b0;
        cmd_op = 2'h0;
        cmd_action = 3'h0;
        cmd_ns = '0;
        cmd_host = '0;
        ignore_key_bit = 1'b0;
        reservation_type_field = 8'h00;
        current_key_field = '0;
        preempt_key_field = '0;
    end

    // Gap lets the host be slow; key lines scramble once released
    task automatic send(input logic [1:0] op, input logic [2:0] act,
                        input logic [2:0] h, input logic ik,
                        input logic [NS_WIDTH-1:0] ns,
                        input logic [7:0] typ, input logic [63:0] ck,
                        input logic [63:0] pk, input int gap,
                        output logic [25:0] res, output logic ok);
        int n;
        ok = 1'b0;
        res = '0;
        repeat (gap + 1) @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_action <= act;
        cmd_host <= h;
        cmd_ns <= ns;
        ignore_key_bit <= ik;
        reservation_type_field <= typ;
        current_key_field <= ck;
        preempt_key_field <= pk;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk);
            if (cmd_ready === 1'b1)
                break;
        end
        cmd_valid <= 1'b0;
        current_key_field <= ~ck;
        preempt_key_field <= ~pk;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk);
            if (cpl_valid === 1'b1)
            begin
                res = {cpl_status, released_notify, preempted_notify,
                       abort_request};
                ok = 1'b1;
                break;
            end
        end
    endtask
endmodule

// [namespace_reservation_arbiter_tb.sv]
module namespace_reservation_arbiter_tb
    import resv_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic cmd_valid;
    logic cmd_ready;
    logic [1:0] cmd_op;
    logic [2:0] cmd_action;
    logic [NS_WIDTH-1:0] cmd_ns;
    logic [HOST_WIDTH-1:0] cmd_host;
    logic ignore_key_bit;
    logic [7:0] reservation_type_field;
    logic [63:0] current_key_field;
    logic [63:0] preempt_key_field;
    logic cpl_valid;
    logic [1:0] cpl_status;
    logic [HOST_WIDTH-1:0] cpl_host;
    logic [HOST_COUNT-1:0] released_notify;
    logic [HOST_COUNT-1:0] preempted_notify;
    logic [HOST_COUNT-1:0] abort_request;
    logic [NS_WIDTH-1:0] event_ns;
    int fail_count = 0;
    int cmp_count = 0;
    int err_count = 0;
    int gap = 0;
    logic [1:0] last_st = 2'h0;
    logic ik = 1'b0;
    logic [NS_WIDTH-1:0] ns = '0;
    logic [25:0] res;

    namespace_reservation_arbiter uut (.*);
    resv_host_model host (.*);

    always #20 clk = ~clk;

    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk);
            if (wb_ack_o === 1'b1)
                break;
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n == 50)
        begin
            fail_count++;
            stop_test();
        end
    endtask

    // Key of host h is 0x11 times h; host 0 stands for the zero key
    function automatic logic [63:0] key(input logic [2:0] h);
        return {56'h00_0000_0000_0000, 1'b0, h, 1'b0, h};
    endfunction

    task automatic enroll(input logic [2:0] h);
        logic [31:0] q;
        wb(1'b1, 8'h00, 32'(key(h)), q);
        wb(1'b1, 8'h04, 32'h0000_0000, q);
        wb(1'b1, 8'h08, {27'h000_0000, 2'h2, h}, q);
    endtask

    task automatic go(input logic [1:0] op, input logic [2:0] act,
                      input logic [2:0] h, input logic [7:0] typ,
                      input logic [2:0] ck, input logic [2:0] pk);
        logic ok;
        host.send(op, act, h, ik, ns, typ, key(ck), key(pk), gap, res, ok);
        gap = (gap == 0) ? 2 : 0;
        if (ok !== 1'b1)
        begin
            fail_count++;
            stop_test();
        end
    endtask

    task automatic chk(input logic [1:0] st, input logic [7:0] rl,
                       input logic [7:0] pr, input logic [7:0] ab);
        cmp({6'h00, res}, {6'h00, st, rl, pr, ab});
        if (st != STS_SUCCESS)
            err_count++;
        last_st = st;
    endtask

    task automatic regs(input logic [7:0] e);
        logic [31:0] q;
        wb(1'b0, 8'h10, 32'h0000_0000, q);
        cmp({16'h0000, q[15:8], 6'h00, q[1:0]}, {16'h0000, e, 8'h00});
    endtask

    initial
    begin
        logic [31:0] q;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        enroll(3'h1);
        enroll(3'h2);
        enroll(3'h3);
        go(OP_ACQUIRE, ACQ_ACQUIRE, 3'h4, 8'h01, 3'h4, 3'h0);
        chk(STS_CONFLICT, 8'h00, 8'h00, 8'h00);
        go(OP_ACQUIRE, ACQ_ACQUIRE, 3'h1, 8'h01, 3'h2, 3'h0);
        chk(STS_CONFLICT, 8'h00, 8'h00, 8'h00);
        ik = 1'b1;
        go(OP_ACQUIRE, ACQ_ACQUIRE, 3'h1, 8'h01, 3'h2, 3'h0);
        chk(STS_SUCCESS, 8'h00, 8'h00, 8'h00);
        ik = 1'b0;
        go(OP_ACQUIRE, ACQ_ACQUIRE, 3'h2, 8'h01, 3'h2, 3'h0);
        chk(STS_CONFLICT, 8'h00, 8'h00, 8'h00);
        go(OP_ACQUIRE, ACQ_ACQUIRE, 3'h1, 8'h01, 3'h1, 3'h0);
        chk(STS_SUCCESS, 8'h00, 8'h00, 8'h00);
        go(OP_ACQUIRE, ACQ_ACQUIRE, 3'h1, 8'h02, 3'h1, 3'h0);
        chk(STS_CONFLICT, 8'h00, 8'h00, 8'h00);
        go(OP_RELEASE, REL_RELEASE, 3'h2, 8'h01, 3'h2, 3'h0);
        chk(STS_SUCCESS, 8'h00, 8'h00, 8'h00);
        go(OP_RELEASE, REL_RELEASE, 3'h1, 8'h02, 3'h1, 3'h0);
        chk(STS_INVALID, 8'h00, 8'h00, 8'h00);
        go(OP_RELEASE, REL_RELEASE, 3'h1, 8'h01, 3'h2, 3'h0);
        chk(STS_CONFLICT, 8'h00, 8'h00, 8'h00);
        go(OP_RELEASE, REL_RELEASE, 3'h1, 8'h01, 3'h1, 3'h0);
        chk(STS_SUCCESS, 8'h00, 8'h00, 8'h00);
        go(OP_ACQUIRE, ACQ_ACQUIRE, 3'h1, 8'h05, 3'h1, 3'h0);
        chk(STS_SUCCESS, 8'h00, 8'h00, 8'h00);
        go(OP_RELEASE, REL_RELEASE, 3'h1, 8'h05, 3'h1, 3'h0);
        chk(STS_SUCCESS, 8'h0c, 8'h00, 8'h00);
        go(OP_ACQUIRE, ACQ_PREEMPT, 3'h1, 8'h01, 3'h1, 3'h3);
        chk(STS_SUCCESS, 8'h00, 8'h08, 8'h00);
        regs(8'h06);
        enroll(3'h3);
        go(OP_ACQUIRE, ACQ_ACQUIRE, 3'h2, 8'h01, 3'h2, 3'h0);
        chk(STS_SUCCESS, 8'h00, 8'h00, 8'h00);
        go(OP_ACQUIRE, ACQ_PREEMPT_ABORT, 3'h1, 8'h02, 3'h1, 3'h2);
        chk(STS_SUCCESS, 8'h08, 8'h04, 8'h04);
        regs(8'h0a);
        go(OP_ACQUIRE, ACQ_PREEMPT, 3'h1, 8'h02, 3'h1, 3'h0);
        chk(STS_INVALID, 8'h00, 8'h00, 8'h00);
        enroll(3'h2);
        go(OP_ACQUIRE, ACQ_PREEMPT, 3'h3, 8'h02, 3'h3, 3'h2);
        chk(STS_SUCCESS, 8'h00, 8'h04, 8'h00);
        go(OP_ACQUIRE, ACQ_ACQUIRE, 3'h3, 8'h02, 3'h3, 3'h0);
        chk(STS_CONFLICT, 8'h00, 8'h00, 8'h00);
        go(OP_ACQUIRE, ACQ_PREEMPT, 3'h1, 8'h05, 3'h1, 3'h1);
        chk(STS_SUCCESS, 8'h08, 8'h00, 8'h00);
        regs(8'h0a);
        go(OP_ACQUIRE, ACQ_PREEMPT, 3'h3, 8'h06, 3'h3, 3'h0);
        chk(STS_SUCCESS, 8'h00, 8'h02, 8'h00);
        regs(8'h08);
        enroll(3'h1);
        enroll(3'h2);
        go(OP_ACQUIRE, ACQ_PREEMPT, 3'h3, 8'h06, 3'h3, 3'h2);
        chk(STS_SUCCESS, 8'h00, 8'h04, 8'h00);
        regs(8'h0a);
        go(OP_RELEASE, 3'h1, 3'h3, 8'h06, 3'h3, 3'h0);
        chk(STS_INVALID, 8'h00, 8'h00, 8'h00);
        // Registration in one namespace grants nothing in another
        ns = 2'h1;
        go(OP_ACQUIRE, ACQ_ACQUIRE, 3'h1, 8'h01, 3'h1, 3'h0);
        chk(STS_CONFLICT, 8'h00, 8'h00, 8'h00);
        cmp({30'h0000_0000, event_ns}, 32'h0000_0001);
        wb(1'b0, 8'h00, 32'h0000_0000, q);
        cmp(q, 32'h0000_0022);
        wb(1'b0, 8'h0c, 32'h0000_0000, q);
        cmp({22'h00_0000, q[9:0]}, {22'h00_0000, last_st, err_count[7:0]});
        wb(1'b0, 8'h20, 32'h0000_0000, q);
        cmp(q, 32'h0000_0000);
        stop_test();
    end
endmodule
